// ---- core/pcs_pkg.sv ----
/*
 Shared types and constants of the clock synthesiser supervisor.
 Assumes one clock domain (mclk) and a synchronous active-high reset.
*/
// How it works
// [RULE1] Lock loss with its reset enable set asserts chip reset.
// [RULE2] Reset clears lock flags; a lock-loss cause bit survives for software.
// [RULE3] In synthesiser mode reset is held until reference present and lock.
// [RULE4] External clock mode raises no lock loss; its reset enable is ignored.
// [RULE5] With detection enabled, reference or feedback loss sets sticky flag.
// [RULE6] Clock loss monitor is off in external clock mode.
// [RULE7] Clock loss with its reset enable set asserts chip reset.
// [RULE8] Reset clears the clock loss flag; a clock-loss cause bit is kept.
// [RULE9] Clock loss reset enable does nothing in external clock mode.
// [RULE10] Reference failure moves to self-clocked mode until next reset.
// [RULE11] Self-clocked clock is still divided by the output divider field.
// [RULE12] Synthesiser failure with good reference selects reference until reset.
// [RULE13] Double failure: reference handling wins; self-clocked or else static.
// [RULE14] Reset exit after double failure waits for reference and synthesiser.
// [RULE15] In stop the synthesiser stays powered only for field 00 or 01.
// [RULE16] In stop the oscillator stays on for 00, 01, 10 or external reference.
// [RULE17] Loss in stop with matching reset enable resets immediately.
// [RULE18] Reference loss in stop wakes self-clocked, lock flags 0, loss flag 1.
// [RULE19] Feedback loss in stop wakes in reference mode, loss flag set.
// [RULE20] With detection disabled, loss in stop leaves the loss flag unchanged.
// [RULE21] Sticky lock keeps pre-stop value if synthesiser was off; else 0.
// [RULE22] Fast wakeup shows lock 0 and loss 1 until recovery, then restores.
// [RULE23] Source switching is registered, glitch free and judged on live clocks.
// [RULE24] Synthesiser failure with detection disabled leaves the clock static.
package pcs_pkg;
   localparam int SYNC_STAGES = 2;
   localparam logic [1:0] STOP_SYNTH_MAX = 2'h1;
   localparam logic [1:0] STOP_OSC_MAX = 2'h2;
   localparam logic [2:0] DIV_RESET = 3'h0;

   typedef enum {
      SRC_SYNTH, SRC_SCM, SRC_REF, SRC_EXT, SRC_STATIC
   } pcs_src_e;

   typedef struct packed {
      logic external_clock_mode;
      logic lock_loss_reset_enable;
      logic clock_loss_detect_enable;
      logic clock_loss_reset_enable;
      logic fast_wakeup;
      logic external_reference;
      logic [1:0] stop_power_select;
      logic [2:0] output_divider_field;
   } pcs_cfg_s;

   typedef struct packed {
      logic lock_flag;
      logic sticky_lock_flag;
      logic sticky_clock_loss_flag;
   } pcs_status_s;

   typedef struct packed {
      logic lock_loss_cause;
      logic clock_loss_cause;
   } pcs_cause_s;
endpackage

// ---- core/pcs_supervisor.sv ----
/*
 Clock synthesiser supervisor: loss-of-lock and loss-of-clock detection,
 sticky status, chip reset request with cause, fallback source selection
 and stop-mode power and flag handling.
 Assumes the analog status pins are asynchronous to mclk, that rst is the
 warm reset driven by the reset controller, and por the power-on reset.
*/
`timescale 1ns/1ps
module pcs_supervisor (
   input wire logic mclk,
   input wire logic rst,
   input wire logic por,
   input wire pcs_pkg::pcs_cfg_s cfg,
   input wire logic stop_req,
   input wire logic mfd_change,
   input wire logic ref_ok_pin,
   input wire logic fb_ok_pin,
   input wire logic lock_pin,
   input wire logic scm_ok_pin,
   output pcs_pkg::pcs_status_s status_q,
   output pcs_pkg::pcs_cause_s cause_q,
   output pcs_pkg::pcs_src_e clk_src_q,
   output logic [2:0] clk_div_q,
   output logic chip_reset_q,
   output logic reset_hold_q,
   output logic synth_power_q,
   output logic osc_power_q
);
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic ref_s, fb_s, lock_s, scm_s;
   logic lock_prev_q, loc_prev_q, stop_prev_q;
   logic sticky_lock_q, sticky_loc_q, ever_locked_q;
   logic frozen_q, synth_off_stop_q, blk_lock_q, blk_loc_q;
   logic normal, synth_on, osc_on, synth_live, osc_live;
   logic ref_lost, fb_lost, loc_cond, loc_evt, lol_evt;
   logic stop_entry, stop_exit, stop_rst, lol_rst, loc_rst, req_now;

   // Two flops before any logic looks at the analog status pins.
   // Not reset: the hold logic must see live pins while rst stands,
   // or the chip could never leave reset.
   always_ff @(posedge mclk) begin
      sync1_q <= {scm_ok_pin, lock_pin, fb_ok_pin, ref_ok_pin};
      sync2_q <= sync1_q;
   end
   assign ref_s = sync2_q[0];
   assign fb_s = sync2_q[1];
   assign lock_s = sync2_q[2];
   assign scm_s = sync2_q[3];

   assign normal = !cfg.external_clock_mode;
   assign synth_on = cfg.stop_power_select <= pcs_pkg::STOP_SYNTH_MAX; // [RULE15]
   assign osc_on = cfg.external_reference
      || (cfg.stop_power_select <= pcs_pkg::STOP_OSC_MAX); // [RULE16]
   assign synth_live = !stop_req || synth_on;
   assign osc_live = !stop_req || osc_on;
   assign stop_entry = stop_req && !stop_prev_q;
   assign stop_exit = !stop_req && stop_prev_q;

   // A clock powered down on purpose is not a failure
   assign ref_lost = osc_live && !ref_s;
   assign fb_lost = synth_live && !fb_s && !blk_loc_q;
   assign loc_cond = normal && cfg.clock_loss_detect_enable
      && (ref_lost || fb_lost); // [RULE5] [RULE6]
   assign loc_evt = loc_cond && !loc_prev_q;
   // MFD changes drop lock intentionally and never count as a loss
   assign lol_evt = normal && lock_prev_q && !lock_s && !mfd_change
      && synth_live && clk_src_q == pcs_pkg::SRC_SYNTH; // [RULE4]

   assign lol_rst = lol_evt && cfg.lock_loss_reset_enable; // [RULE1]
   assign loc_rst = loc_evt && cfg.clock_loss_reset_enable; // [RULE7]
   // Powering the synthesiser down in stop loses lock and clocks at once
   assign stop_rst = stop_entry && !synth_on
      && (cfg.lock_loss_reset_enable || (cfg.clock_loss_detect_enable
      && cfg.clock_loss_reset_enable)); // [RULE17]
   assign req_now = normal && (lol_rst || loc_rst || stop_rst); // [RULE9]

   always_ff @(posedge mclk) begin
      if (rst) begin
         lock_prev_q <= 1'b0;
         loc_prev_q <= 1'b0;
         stop_prev_q <= 1'b0;
      end else begin
         lock_prev_q <= lock_s;
         loc_prev_q <= loc_cond;
         stop_prev_q <= stop_req;
      end
   end

   // Chip reset request stays until the reset controller answers with rst
   always_ff @(posedge mclk) begin
      if (rst) begin
         chip_reset_q <= 1'b0;
      end else if (req_now) begin
         chip_reset_q <= 1'b1;
      end
   end

   // Cause bits outlive the warm reset so software can read them after it
   always_ff @(posedge mclk) begin
      if (por) begin
         cause_q <= '0;
      end else if (!rst && req_now && !chip_reset_q) begin
         cause_q.lock_loss_cause <= lol_rst
            || (stop_rst && cfg.lock_loss_reset_enable); // [RULE2]
         cause_q.clock_loss_cause <= loc_rst || (stop_rst
            && cfg.clock_loss_detect_enable
            && cfg.clock_loss_reset_enable); // [RULE8]
      end
   end

   // Sticky lock is set by the first lock only; an unexpected loss keeps it 0
   always_ff @(posedge mclk) begin
      if (rst) begin
         sticky_lock_q <= 1'b0;
         ever_locked_q <= 1'b0;
      end else if (lol_evt || loc_evt) begin
         sticky_lock_q <= 1'b0; // [RULE18] [RULE19] [RULE21]
      end else if (normal && lock_s && !ever_locked_q && !frozen_q) begin
         sticky_lock_q <= 1'b1;
         ever_locked_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sticky_loc_q <= 1'b0; // [RULE8]
      end else if (loc_evt) begin
         sticky_loc_q <= 1'b1; // [RULE5] [RULE20]
      end
   end

   // Synthesiser off in stop: hold sticky lock at its pre-stop value
   always_ff @(posedge mclk) begin
      if (rst) begin
         frozen_q <= 1'b0;
         synth_off_stop_q <= 1'b0;
      end else begin
         if (stop_entry) begin
            synth_off_stop_q <= !synth_on;
         end
         if (stop_entry && !synth_on) begin
            frozen_q <= 1'b1;
         end else if (!stop_req && lock_s) begin
            frozen_q <= 1'b0; // [RULE21]
         end
      end
   end

   // Fast wakeup masks the flags until lock and clocks come back
   always_ff @(posedge mclk) begin
      if (rst) begin
         blk_lock_q <= 1'b0;
         blk_loc_q <= 1'b0;
      end else begin
         if (stop_exit && cfg.fast_wakeup && synth_off_stop_q && !lock_s) begin
            blk_lock_q <= 1'b1; // [RULE22]
         end else if (lock_s) begin
            blk_lock_q <= 1'b0;
         end
         if (stop_exit && cfg.fast_wakeup && synth_off_stop_q
               && !(ref_s && fb_s)) begin
            blk_loc_q <= 1'b1; // [RULE22]
         end else if (ref_s && fb_s) begin
            blk_loc_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         status_q <= '0;
      end else begin
         status_q.lock_flag <= normal && lock_s && !blk_lock_q
            && clk_src_q == pcs_pkg::SRC_SYNTH; // [RULE4]
         status_q.sticky_lock_flag <= sticky_lock_q && !blk_lock_q;
         status_q.sticky_clock_loss_flag <= sticky_loc_q || blk_loc_q;
      end
   end

   // Source changes at most twice per reset (synth to self-clocked to static); the clock mux switches on this register
   always_ff @(posedge mclk) begin
      if (rst) begin
         clk_src_q <= cfg.external_clock_mode ? pcs_pkg::SRC_EXT
            : pcs_pkg::SRC_SYNTH;
      end else begin
         unique case (clk_src_q)
            pcs_pkg::SRC_SYNTH: begin
               if (normal && !cfg.clock_loss_detect_enable && fb_lost) begin
                  clk_src_q <= pcs_pkg::SRC_STATIC; // [RULE24]
               end else if (loc_cond && ref_lost) begin
                  clk_src_q <= scm_s ? pcs_pkg::SRC_SCM
                     : pcs_pkg::SRC_STATIC; // [RULE10] [RULE13] [RULE18]
               end else if (loc_cond) begin
                  clk_src_q <= pcs_pkg::SRC_REF; // [RULE12] [RULE19]
               end
            end
            pcs_pkg::SRC_SCM: begin
               if (!scm_s) begin
                  clk_src_q <= pcs_pkg::SRC_STATIC; // [RULE13] [RULE23]
               end
            end
            pcs_pkg::SRC_REF, pcs_pkg::SRC_EXT, pcs_pkg::SRC_STATIC: begin
               clk_src_q <= clk_src_q;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         clk_div_q <= pcs_pkg::DIV_RESET;
      end else begin
         clk_div_q <= cfg.output_divider_field; // [RULE11]
      end
   end

   // Evaluated during rst too: this is what releases the reset
   always_ff @(posedge mclk) begin
      reset_hold_q <= normal && !(ref_s && fb_s && lock_s); // [RULE3] [RULE14]
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         synth_power_q <= 1'b1;
         osc_power_q <= 1'b1;
      end else begin
         synth_power_q <= !stop_req || synth_on; // [RULE15]
         osc_power_q <= !stop_req || osc_on; // [RULE16]
      end
   end

   a_lol_reset: assert property (@(posedge mclk) disable iff (rst) // [RULE1]
      lol_evt && cfg.lock_loss_reset_enable && !chip_reset_q
      |=> chip_reset_q && cause_q.lock_loss_cause)
      else $error("lock loss did not reset");
   a_ext_no_reset: assert property (@(posedge mclk) disable iff (rst) // [RULE9]
      cfg.external_clock_mode && !chip_reset_q |=> !chip_reset_q)
      else $error("reset raised in external mode");
   a_flags_cleared: assert property (@(posedge mclk) // [RULE2]
      $past(rst) && rst |-> !status_q.sticky_lock_flag
      && !status_q.sticky_clock_loss_flag && !status_q.lock_flag)
      else $error("flags not cleared by reset");
   a_loc_flag_set: assert property (@(posedge mclk) disable iff (rst) // [RULE5]
      loc_evt |=> ##1 status_q.sticky_clock_loss_flag)
      else $error("clock loss flag not set");
   a_loc_disabled: assert property (@(posedge mclk) disable iff (rst) // [RULE20]
      !cfg.clock_loss_detect_enable && !sticky_loc_q |=> !sticky_loc_q)
      else $error("loss flag set with detection off");
   a_scm_kept: assert property (@(posedge mclk) disable iff (rst) // [RULE10]
      clk_src_q == pcs_pkg::SRC_SCM
      |=> clk_src_q inside {pcs_pkg::SRC_SCM, pcs_pkg::SRC_STATIC})
      else $error("left self-clocked mode");
   a_ref_kept: assert property (@(posedge mclk) disable iff (rst) // [RULE12]
      clk_src_q == pcs_pkg::SRC_REF |=> clk_src_q == pcs_pkg::SRC_REF)
      else $error("left reference mode");
   a_synth_off: assert property (@(posedge mclk) disable iff (rst) // [RULE15]
      stop_req && cfg.stop_power_select > pcs_pkg::STOP_SYNTH_MAX
      |=> !synth_power_q)
      else $error("synthesiser powered in deep stop");
   a_hold_lock: assert property (@(posedge mclk) // [RULE3]
      normal && !lock_s |=> reset_hold_q)
      else $error("reset released without lock");
   a_div_follow: assert property (@(posedge mclk) disable iff (rst) // [RULE11]
      $stable(cfg.output_divider_field)
      |=> clk_div_q == $past(cfg.output_divider_field))
      else $error("divider not applied");
endmodule

// ---- dv/pcs_rst_model.sv ----
/*
 Model of the chip reset controller facing the supervisor.
 Assumes it shares mclk with the bench and acts on the falling edge.
*/
`timescale 1ns/1ps
module pcs_rst_model (
   input wire logic mclk,
   input wire logic tb_rst,
   input wire logic chip_reset_q,
   input wire logic reset_hold_q,
   output logic rst,
   output logic [7:0] reset_count
);
   logic [2:0] pulse_q;
   logic hold_q;
   initial begin
      pulse_q = 3'h0;
      hold_q = 1'b0;
      reset_count = 8'h00;
   end
   // Stretched so the pin synchronisers flush before release
   always @(negedge mclk) begin
      if (chip_reset_q && pulse_q == 3'h0) begin
         reset_count <= reset_count + 8'h01;
      end
      if (chip_reset_q) begin
         pulse_q <= 3'h4;
      end else if (pulse_q != 3'h0) begin
         pulse_q <= pulse_q - 3'h1;
      end
   end
   // Only an ongoing reset is extended, so a live loss is never masked
   always @(negedge mclk) begin
      hold_q <= rst && reset_hold_q;
   end
   assign rst = tb_rst || pulse_q != 3'h0 || hold_q;
endmodule

// ---- dv/testbench.sv ----
/*
 Self-checking bench for the clock synthesiser supervisor.
 Assumes the reset controller model drives rst; inputs move at negedge.
*/
`timescale 1ns/1ps
module testbench;
   logic mclk, tb_rst, rst, por, stop_req, mfd_change;
   logic ref_ok_pin, fb_ok_pin, lock_pin, scm_ok_pin;
   pcs_pkg::pcs_cfg_s cfg;
   pcs_pkg::pcs_status_s status_q;
   pcs_pkg::pcs_cause_s cause_q;
   pcs_pkg::pcs_src_e clk_src_q;
   logic [2:0] clk_div_q;
   logic chip_reset_q, reset_hold_q, synth_power_q, osc_power_q;
   logic [7:0] reset_count, n0;
   int bad_count, checked;

   pcs_supervisor dut_u (.mclk(mclk), .rst(rst), .por(por), .cfg(cfg),
      .stop_req(stop_req), .mfd_change(mfd_change),
      .ref_ok_pin(ref_ok_pin), .fb_ok_pin(fb_ok_pin), .lock_pin(lock_pin),
      .scm_ok_pin(scm_ok_pin), .status_q(status_q), .cause_q(cause_q),
      .clk_src_q(clk_src_q), .clk_div_q(clk_div_q),
      .chip_reset_q(chip_reset_q), .reset_hold_q(reset_hold_q),
      .synth_power_q(synth_power_q), .osc_power_q(osc_power_q));
   pcs_rst_model rc_u (.mclk(mclk), .tb_rst(tb_rst),
      .chip_reset_q(chip_reset_q), .reset_hold_q(reset_hold_q),
      .rst(rst), .reset_count(reset_count));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic pins_good;
      {ref_ok_pin, fb_ok_pin, lock_pin, scm_ok_pin} = 4'hF;
   endtask
   task automatic do_reset;
      tb_rst = 1'b1;
      tick(6);
      tb_rst = 1'b0;
      tick(6);
   endtask

   task automatic t_fb_loss;
      cfg.clock_loss_detect_enable = 1'b1;
      fb_ok_pin = 1'b0;
      tick(5);
      chk("src", pcs_pkg::SRC_REF, clk_src_q);
      chk("sticky_clock_loss_flag", 1'b1, status_q.sticky_clock_loss_flag);
      chk("creset", 1'b0, chip_reset_q);
      fb_ok_pin = 1'b1;
      lock_pin = 1'b0;
      tick(3);
      lock_pin = 1'b1;
      tick(5);
      chk("src relock", pcs_pkg::SRC_REF, clk_src_q);
      do_reset;
      chk("src", pcs_pkg::SRC_SYNTH, clk_src_q);
      chk("sticky_clock_loss_flag", 1'b0, status_q.sticky_clock_loss_flag);
   endtask
   task automatic t_ref_loss;
      cfg.output_divider_field = 3'h5;
      cfg.clock_loss_reset_enable = 1'b1;
      n0 = reset_count;
      tick(2);
      ref_ok_pin = 1'b0;
      tick(3);
      chk("creset", 1'b1, chip_reset_q);
      chk("cause", 2'h1, cause_q);
      chk("src", pcs_pkg::SRC_SCM, clk_src_q);
      chk("div", 3'h5, clk_div_q);
      tick(8);
      chk("rst", 1'b1, rst);
      chk("status", 3'h0, status_q);
      ref_ok_pin = 1'b1;
      tick(8);
      chk("rst", 1'b0, rst);
      chk("cause", 2'h1, cause_q);
      chk("resets", n0 + 8'h01, reset_count);
      chk("src", pcs_pkg::SRC_SYNTH, clk_src_q);
   endtask
   task automatic t_double;
      cfg.clock_loss_reset_enable = 1'b0;
      {ref_ok_pin, fb_ok_pin, scm_ok_pin} = 3'h0;
      tick(4);
      chk("src", pcs_pkg::SRC_STATIC, clk_src_q);
      pins_good;
      do_reset;
   endtask
   task automatic t_lol;
      cfg.clock_loss_detect_enable = 1'b0;
      cfg.lock_loss_reset_enable = 1'b1;
      lock_pin = 1'b0;
      tick(3);
      chk("creset", 1'b1, chip_reset_q);
      lock_pin = 1'b1;
      tick(12);
      chk("cause", 2'h2, cause_q);
      chk("lock", 1'b1, status_q.lock_flag);
   endtask
   task automatic t_ext;
      cfg = '0;
      cfg.external_clock_mode = 1'b1;
      {cfg.lock_loss_reset_enable, cfg.clock_loss_detect_enable} = 2'h3;
      cfg.clock_loss_reset_enable = 1'b1;
      do_reset;
      {ref_ok_pin, fb_ok_pin, lock_pin} = 3'h0;
      tick(6);
      chk("creset", 1'b0, chip_reset_q);
      chk("sticky_clock_loss_flag", 1'b0, status_q.sticky_clock_loss_flag);
      chk("src", pcs_pkg::SRC_EXT, clk_src_q);
      pins_good;
      cfg = '0;
      do_reset;
   endtask
   task automatic t_stop;
      for (int s = 0; s < 4; s++) begin
         cfg.stop_power_select = s[1:0];
         stop_req = 1'b1;
         tick(3);
         chk("synth pwr", s <= 1, synth_power_q);
         chk("osc pwr", s <= 2, osc_power_q);
         stop_req = 1'b0;
         tick(3);
      end
      cfg.stop_power_select = 2'h2;
      cfg.lock_loss_reset_enable = 1'b1;
      n0 = reset_count;
      stop_req = 1'b1;
      tick(4);
      chk("stop reset", n0 + 8'h01, reset_count);
      stop_req = 1'b0;
      tick(10);
   endtask

   initial begin
      #(25 * 4000);
      bad_count++;
      stop_test;
   end

   initial begin
      cfg = '0;
      {tb_rst, por, stop_req, mfd_change, lock_pin} = 5'h18;
      {ref_ok_pin, fb_ok_pin, scm_ok_pin} = 3'h7;
      bad_count = 0;
      checked = 0;
      tick(6);
      {tb_rst, por} = 2'h0;
      tick(4);
      chk("rst no lock", 1'b1, rst);
      lock_pin = 1'b1;
      tick(8);
      chk("rst", 1'b0, rst);
      chk("sticky_lock_flag", 1'b1, status_q.sticky_lock_flag);
      chk("pwr", 2'h3, {synth_power_q, osc_power_q});
      t_fb_loss;
      t_ref_loss;
      t_double;
      t_lol;
      t_ext;
      t_stop;
      stop_test;
   end
endmodule
